// ==== src/csbw_engine.sv ====
// chip select bus cycle engine: single, back-to-back and burst line cycles
//
// Contract
// - wait_state_count zero gives no wait; n stretches chip select low by n clocks.
// - write start on rising edge drives valid address and read_write_n low.
// - chip select of the addressed region asserts on falling edge of second state.
// - write data leaves high impedance on rising edge of third state.
// - without acknowledge at end of second clock, insert whole wait clocks.
// - auto-acknowledge makes the acknowledge internally, ignoring the external one.
// - acknowledge is negated in the fifth state, externally or internally.
// - final state negates chip select on falling edge, releases address, data.
// - the edge ending a cycle may start the next access directly.
// - accesses wider than the port split into consecutive back-to-back cycles.
// - any read/write mix runs back to back, chosen by hardware alone.
// - burst enable set and size above port width issues a burst.
// - line burst to a sixteen-bit port is eight word beats.
// - bursts run three-clock first beat, two-clock later beats, waits stretch termination.
// - both burst enables clear turns a line into back-to-back single cycles.
// - line is sixteen aligned bytes; start longword from address bits three, two.
// - longword beats wrap upward from the starting offset.
// - burst read samples first beat like basic read, later beats two clocks apart.
// - chip select and output enable stay asserted through a whole burst read.
// - burst write drives each next beat on the same edge at which the previous registers.
// - programmed wait states also apply to every burst read beat.
// - reads assert output enable with chip select; both negate in final state.
`default_nettype none
module csbw_engine #(
  parameter int NUM_CS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] wait_state_count,
  input wire logic auto_ack_en,
  input wire logic burst_read_en,
  input wire logic burst_write_en,
  input wire logic port_is_16,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [$clog2(NUM_CS)-1:0] req_cs,
  input wire logic [127:0] req_wdata,
  output logic rsp_valid,
  output logic [127:0] rsp_rdata,
  output logic [31:0] bus_addr,
  output logic bus_addr_oe,
  output logic read_write_n,
  output logic [NUM_CS-1:0] chip_select_n,
  output logic output_enable_n,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [31:0] data_in,
  input wire logic transfer_acknowledge_n,
  output logic busy
);
  // refused at elaboration: the select index must name every region exactly
  if (NUM_CS < 2 || NUM_CS > 8 || (NUM_CS & (NUM_CS - 1)) != 0) begin
    $error("NUM_CS must be a power of two between 2 and 8");
  end

  csbw_pkg::csbw_state_e state;
  csbw_pkg::csbw_state_e next_state;
  logic [31:0] line_addr;
  logic [1:0] size;
  logic write;
  logic p16;
  logic burst;
  logic [$clog2(NUM_CS)-1:0] cs_sel;
  logic [127:0] wbuf;
  logic [3:0] beat;
  logic [3:0] nbeats;
  logic [3:0] ws_cnt;
  logic [31:0] din_meta;
  logic [31:0] din_sync;
  logic ta_meta;
  logic ta_sync;
  logic cs_active;
  logic ack_now;
  logic last_beat;
  logic take;

  // beats needed for a size on a port width
  function automatic logic [3:0] beat_count(input logic [1:0] sz, input logic w16);
    if (sz == csbw_pkg::SIZE_LINE) begin
      beat_count = w16 ? csbw_pkg::BEATS_LINE_W16 : csbw_pkg::BEATS_LINE_W32;
    end else if (sz == csbw_pkg::SIZE_LONG && w16) begin
      beat_count = csbw_pkg::BEATS_LONG_W16;
    end else begin
      beat_count = csbw_pkg::BEATS_SINGLE;
    end
  endfunction

  // longword slot of a beat; lines wrap upward from address bits three, two
  function automatic logic [1:0] beat_slot(input logic [31:0] a, input logic [1:0] sz,
                                           input logic w16, input logic [3:0] k);
    logic [1:0] li;
    li = w16 ? k[2:1] : k[1:0];
    if (sz == csbw_pkg::SIZE_LINE) begin
      beat_slot = a[3:2] + li;
    end else begin
      beat_slot = 2'h0;
    end
  endfunction

  // word half within a longword on a sixteen-bit port: upper word first
  function automatic logic beat_half(input logic [1:0] sz, input logic w16,
                                     input logic [3:0] k);
    beat_half = w16 && sz >= csbw_pkg::SIZE_LONG && k[0];
  endfunction

  function automatic logic [31:0] beat_addr(input logic [31:0] a, input logic [1:0] sz,
                                            input logic w16, input logic [3:0] k);
    if (sz == csbw_pkg::SIZE_LINE) begin
      beat_addr = {a[31:4], beat_slot(a, sz, w16, k), beat_half(sz, w16, k), 1'b0};
    end else if (sz == csbw_pkg::SIZE_LONG && w16) begin
      beat_addr = {a[31:2], beat_half(sz, w16, k), 1'b0};
    end else begin
      beat_addr = a;
    end
  endfunction

  function automatic logic [31:0] beat_wdata(input logic [127:0] buf_in, input logic [31:0] a,
                                             input logic [1:0] sz, input logic w16,
                                             input logic [3:0] k);
    logic [31:0] lw;
    lw = buf_in[beat_slot(a, sz, w16, k)*csbw_pkg::LONG_BITS +: csbw_pkg::LONG_BITS];
    if (w16 && sz >= csbw_pkg::SIZE_LONG) begin
      beat_wdata = {16'h0000, beat_half(sz, w16, k) ? lw[15:0] : lw[31:16]};
    end else begin
      beat_wdata = lw;
    end
  endfunction

  // pins from outside the clock domain pass two flip-flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= 32'h0000_0000;
      din_sync <= 32'h0000_0000;
      ta_meta <= 1'b0;
      ta_sync <= 1'b0;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
      ta_meta <= !transfer_acknowledge_n;
      ta_sync <= ta_meta;
    end
  end

  // internal acknowledge is one clock wide, so it negates on its own afterwards
  always_comb begin
    ack_now = 1'b0;
    if (state == csbw_pkg::CSBW_DATA && ws_cnt >= wait_state_count) begin
      ack_now = auto_ack_en ? 1'b1 : ta_sync;
    end
  end

  assign last_beat = (beat == nbeats - 4'h1);
  // back-to-back accept from the hold state; the far end never sees an idle clock
  assign req_ready = (state == csbw_pkg::CSBW_IDLE) ||
                     (state == csbw_pkg::CSBW_HOLD && last_beat);
  assign take = req_valid && req_ready;
  assign busy = (state != csbw_pkg::CSBW_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      csbw_pkg::CSBW_IDLE: begin
        if (take) begin
          next_state = csbw_pkg::CSBW_ADDR;
        end
      end
      csbw_pkg::CSBW_ADDR: begin
        next_state = csbw_pkg::CSBW_DATA;
      end
      csbw_pkg::CSBW_DATA: begin
        if (ack_now) begin
          // a burst keeps chip select and goes straight to the next beat
          next_state = (burst && !last_beat) ? csbw_pkg::CSBW_NEXT
                                             : csbw_pkg::CSBW_HOLD;
        end
      end
      csbw_pkg::CSBW_NEXT: begin
        next_state = csbw_pkg::CSBW_DATA;
      end
      csbw_pkg::CSBW_HOLD: begin
        if (!last_beat || take) begin
          next_state = csbw_pkg::CSBW_ADDR;
        end else begin
          next_state = csbw_pkg::CSBW_IDLE;
        end
      end
      default: begin
        next_state = csbw_pkg::CSBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= csbw_pkg::CSBW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request capture and beat bookkeeping
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_addr <= csbw_pkg::ADDR_RESET;
      size <= csbw_pkg::SIZE_BYTE;
      write <= 1'b0;
      p16 <= 1'b0;
      burst <= 1'b0;
      cs_sel <= '0;
      wbuf <= 128'h0;
      beat <= 4'h0;
      nbeats <= csbw_pkg::BEATS_SINGLE;
    end else if (take) begin
      line_addr <= req_addr;
      size <= req_size;
      write <= req_write;
      p16 <= port_is_16;
      cs_sel <= req_cs;
      wbuf <= req_wdata;
      beat <= 4'h0;
      nbeats <= beat_count(req_size, port_is_16);
      burst <= (beat_count(req_size, port_is_16) != csbw_pkg::BEATS_SINGLE) &&
               (req_write ? burst_write_en : burst_read_en);
    end else if ((state == csbw_pkg::CSBW_DATA && ack_now && burst && !last_beat) ||
                 (state == csbw_pkg::CSBW_HOLD && !last_beat)) begin
      // split cycles advance on leaving hold, so hold still judges its own beat
      beat <= beat + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ws_cnt <= csbw_pkg::WS_RESET;
    end else if (state != csbw_pkg::CSBW_DATA) begin
      ws_cnt <= csbw_pkg::WS_RESET;
    end else if (ws_cnt != 4'hf) begin
      ws_cnt <= ws_cnt + 4'h1;
    end
  end

  // address and direction: driven from the first rising edge; address released after hold, direction kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_addr <= csbw_pkg::ADDR_RESET;
      bus_addr_oe <= 1'b0;
      read_write_n <= 1'b1;
    end else if (next_state == csbw_pkg::CSBW_ADDR && state == csbw_pkg::CSBW_IDLE) begin
      bus_addr <= beat_addr(req_addr, req_size, port_is_16, 4'h0);
      bus_addr_oe <= 1'b1;
      read_write_n <= !req_write;
    end else if (next_state == csbw_pkg::CSBW_ADDR && take) begin
      bus_addr <= beat_addr(req_addr, req_size, port_is_16, 4'h0);
      read_write_n <= !req_write;
    end else if (next_state == csbw_pkg::CSBW_ADDR || next_state == csbw_pkg::CSBW_NEXT) begin
      bus_addr <= beat_addr(line_addr, size, p16, beat + 4'h1);
    end else if (next_state == csbw_pkg::CSBW_IDLE) begin
      bus_addr_oe <= 1'b0;
    end
  end

  // write data: out of high impedance entering data, next beat entering next
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 32'h0000_0000;
      data_oe <= 1'b0;
    end else if (write && state == csbw_pkg::CSBW_ADDR) begin
      data_out <= beat_wdata(wbuf, line_addr, size, p16, beat);
      data_oe <= 1'b1;
    end else if (write && next_state == csbw_pkg::CSBW_NEXT) begin
      data_out <= beat_wdata(wbuf, line_addr, size, p16, beat + 4'h1);
    end else if (state == csbw_pkg::CSBW_HOLD) begin
      data_oe <= 1'b0;
    end
  end

  // read beats sampled on the acknowledging edge; later burst beats two clocks apart
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_rdata <= 128'h0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state == csbw_pkg::CSBW_DATA) && ack_now && last_beat;
      if (!write && ack_now) begin
        if (p16 && size >= csbw_pkg::SIZE_LONG) begin
          rsp_rdata[beat_slot(line_addr, size, p16, beat)*csbw_pkg::LONG_BITS +
                    (beat_half(size, p16, beat) ? 0 : csbw_pkg::WORD_BITS)
                    +: csbw_pkg::WORD_BITS] <= din_sync[15:0];
        end else begin
          rsp_rdata[beat_slot(line_addr, size, p16, beat)*csbw_pkg::LONG_BITS
                    +: csbw_pkg::LONG_BITS] <= din_sync;
        end
      end
    end
  end

  // falling edge strobes: asserted in address, kept through a burst, dropped in hold
  always_ff @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_active <= 1'b0;
    end else begin
      cs_active <= (state == csbw_pkg::CSBW_ADDR) || (state == csbw_pkg::CSBW_DATA) ||
                   (state == csbw_pkg::CSBW_NEXT);
    end
  end

  always_comb begin
    chip_select_n = {NUM_CS{1'b1}};
    chip_select_n[cs_sel] = !cs_active;
    output_enable_n = !(cs_active && !write);
  end
endmodule
`default_nettype wire

// ==== src/csbw_pkg.sv ====
// shared constants and state encoding of the chip select bus cycle engine
`default_nettype none
package csbw_pkg;
  // transfer size codes on req_size
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;
  // beats per transfer
  localparam logic [3:0] BEATS_SINGLE = 4'h1;
  localparam logic [3:0] BEATS_LONG_W16 = 4'h2;
  localparam logic [3:0] BEATS_LINE_W16 = 4'h8;
  localparam logic [3:0] BEATS_LINE_W32 = 4'h4;
  // line geometry
  localparam int LINE_BYTES = 16;
  localparam int LONG_BITS = 32;
  localparam int WORD_BITS = 16;
  // reset values
  localparam logic [3:0] WS_RESET = 4'h0;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // bus clock figure
  localparam real BUS_CLK_MHZ = 200.0;
  // gray coded along idle, address, data, pipelined beat, hold
  typedef enum logic [2:0] {
    CSBW_IDLE = 3'h0,
    CSBW_ADDR = 3'h1,
    CSBW_DATA = 3'h3,
    CSBW_NEXT = 3'h2,
    CSBW_HOLD = 3'h6
  } csbw_state_e;
endpackage
`default_nettype wire

// ==== tb/csbw_engine_chk.sv ====
// concurrent checks on the ports of the chip select bus cycle engine
`default_nettype none
module csbw_engine_chk #(
  parameter int NUM_CS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] wait_state_count,
  input wire logic auto_ack_en,
  input wire logic burst_read_en,
  input wire logic port_is_16,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic rsp_valid,
  input wire logic bus_addr_oe,
  input wire logic read_write_n,
  input wire logic [NUM_CS-1:0] chip_select_n,
  input wire logic output_enable_n,
  input wire logic data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = req_valid && req_ready;
  sequence s_auto0;
    take && auto_ack_en && wait_state_count == 4'h0;
  endsequence
  sequence s_burst_rd;
    s_auto0 ##0 !req_write && req_size == csbw_pkg::SIZE_LINE && burst_read_en && !port_is_16;
  endsequence
  AST_ONE_SELECT: assert property ($countones(~chip_select_n) <= 1)
    else $error("more than one chip select low");
  AST_NO_WAIT: assert property (s_auto0 ##0 req_size == csbw_pkg::SIZE_BYTE
    |-> ##3 rsp_valid)
    else $error("zero wait cycle not three clocks");
  AST_WAIT_TWO: assert property (take && auto_ack_en && wait_state_count == 4'h2 &&
    req_size == csbw_pkg::SIZE_BYTE |=> !rsp_valid [*4] ##1 rsp_valid)
    else $error("two wait states not inserted");
  AST_ADDR_FIRST: assert property (take |=>
    bus_addr_oe && read_write_n == !$past(req_write))
    else $error("address or direction missing after accept");
  AST_WDATA_LATER: assert property (take && req_write && !bus_addr_oe |=>
    !data_oe ##1 data_oe)
    else $error("write data not one clock after address");
  AST_READ_OE: assert property (
    (chip_select_n != '1 && read_write_n) == !output_enable_n)
    else $error("output enable apart from read select");
  AST_BURST_HOLD: assert property (s_burst_rd |=>
    (!output_enable_n && chip_select_n != '1) [*8] ##1 rsp_valid)
    else $error("select released inside burst read");
  AST_RELEASE: assert property (rsp_valid && !take |=>
    !bus_addr_oe && !data_oe && chip_select_n == '1)
    else $error("bus not released after cycle");
  AST_BACK_TO_BACK: assert property (rsp_valid && take |=>
    bus_addr_oe && chip_select_n != '1)
    else $error("next cycle did not follow at once");
endmodule
bind csbw_engine csbw_engine_chk #(.NUM_CS(NUM_CS)) i_csbw_engine_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .wait_state_count(wait_state_count),
  .auto_ack_en(auto_ack_en), .burst_read_en(burst_read_en), .port_is_16(port_is_16),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_size(req_size),
  .rsp_valid(rsp_valid), .bus_addr_oe(bus_addr_oe), .read_write_n(read_write_n),
  .chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .data_oe(data_oe));
`default_nettype wire

// ==== tb/csbw_mem_model.sv ====
// behavioural memory behind any chip select, answering with its own acknowledge
`default_nettype none
module csbw_mem_model (
  input wire logic ref_clk,
  input wire logic [3:0] lat,
  input wire logic [31:0] bus_addr,
  input wire logic cs_n,
  input wire logic output_enable_n,
  input wire logic data_oe,
  input wire logic [31:0] data_out,
  output logic [31:0] data_in,
  output logic transfer_acknowledge_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic [31:0] last_addr = 32'h0;
  int cnt = 0;
  initial data_in = 32'h0;
  initial transfer_acknowledge_n = 1'b1;
  always @(posedge ref_clk) begin
    cnt = (cs_n || bus_addr != last_addr) ? 0 : cnt + 1;
    last_addr = bus_addr;
    if (!cs_n && data_oe)
      mem[bus_addr[5:2]] = data_out;
    #1;
    // held three clocks: the engine sees pins two clocks late
    transfer_acknowledge_n <= !(cnt >= lat && cnt < lat + 3);
    // released bus toggles so a late sample cannot match
    data_in <= !output_enable_n ? mem[bus_addr[5:2]] : ~data_in;
  end
endmodule
`default_nettype wire

// ==== tb/test_chip_select_bus_write_burst.sv ====
// self-checking bench of the chip select bus cycle engine with its memory model
`default_nettype none
module test_chip_select_bus_write_burst;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, auto_ack_en, burst_read_en, burst_write_en, port_is_16, req_valid;
  logic req_ready, req_write, rsp_valid, bus_addr_oe, read_write_n, output_enable_n;
  logic data_oe, transfer_acknowledge_n, busy, prev_oe;
  logic [3:0] wait_state_count, lat, chip_select_n;
  logic [1:0] req_size, req_cs;
  logic [31:0] req_addr, bus_addr, data_out, data_in, prev_addr, a, d;
  logic [127:0] req_wdata, rsp_rdata;
  logic [32:0] exp_q[$];
  logic [31:0] addr_q[$];
  int error_cnt, n_compared;
  csbw_engine #(.NUM_CS(4)) i_csbw_engine (.ref_clk(ref_clk), .rst_n(rst_n),
    .wait_state_count(wait_state_count), .auto_ack_en(auto_ack_en),
    .burst_read_en(burst_read_en), .burst_write_en(burst_write_en), .port_is_16(port_is_16),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_size(req_size), .req_addr(req_addr), .req_cs(req_cs), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_addr(bus_addr),
    .bus_addr_oe(bus_addr_oe), .read_write_n(read_write_n), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .transfer_acknowledge_n(transfer_acknowledge_n), .busy(busy));
  csbw_mem_model i_csbw_mem_model (.ref_clk(ref_clk), .lat(lat), .bus_addr(bus_addr),
    .cs_n(&chip_select_n), .output_enable_n(output_enable_n), .data_oe(data_oe),
    .data_out(data_out), .data_in(data_in), .transfer_acknowledge_n(transfer_acknowledge_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cfg(logic [3:0] ws, logic au, logic br, logic bw, logic w16, logic [3:0] lt);
    wait_state_count = ws;
    auto_ack_en = au;
    burst_read_en = br;
    burst_write_en = bw;
    port_is_16 = w16;
    lat = lt;
  endtask
  // beat addresses the bus must show, in order
  task automatic expect_beats(logic [31:0] ad, logic [1:0] sz);
    logic [31:0] lw;
    if (sz != csbw_pkg::SIZE_LINE) begin
      addr_q.push_back(ad);
      if (sz == csbw_pkg::SIZE_LONG && port_is_16) addr_q.push_back(ad + 32'h2);
      return;
    end
    for (int i = 0; i < 4; i++) begin
      lw = {ad[31:4], 2'(ad[3:2] + i), 2'h0};
      addr_q.push_back(lw);
      if (port_is_16) addr_q.push_back(lw + 32'h2);
    end
  endtask
  // request stays up until taken; a following call may reuse it back to back
  task automatic issue(logic w, logic [1:0] sz, logic [31:0] ad, logic chk, logic [31:0] dv);
    int k;
    expect_beats(ad, sz);
    exp_q.push_back({chk, dv});
    req_valid = 1'b1;
    req_write = w;
    req_size = sz;
    req_addr = ad;
    req_cs = 2'($urandom);
    req_wdata = {$urandom, $urandom, $urandom, dv};
    for (k = 0; k < 100; k++) begin
      @(posedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    if (k == 100) begin
      error_cnt++;
      summarize();
    end
    #1;
  endtask
  task automatic drain(string name);
    int k;
    req_valid = 1'b0;
    for (k = 0; k < 300 && (exp_q.size() != 0 || busy !== 1'b0); k++) @(posedge ref_clk);
    if (k == 300) begin
      error_cnt++;
      summarize();
    end
    // lets a held acknowledge die away before the next test
    repeat (4) @(posedge ref_clk);
    #1;
    check("left over beats", 32'h0, 32'(addr_q.size()));
    $display("test %s done", name);
  endtask
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'b1 && exp_q.size() == 0) check("extra responses", 32'h0, 32'h1);
    else if (rsp_valid === 1'b1) begin
      if (exp_q[0][32]) check("read data", exp_q[0][31:0], rsp_rdata[31:0]);
      void'(exp_q.pop_front());
    end
    if (bus_addr_oe === 1'b1 && (!prev_oe || bus_addr !== prev_addr)) begin
      if (addr_q.size() == 0) check("extra beats", 32'h0, bus_addr);
      else check("beat address", addr_q.pop_front(), bus_addr);
    end
    prev_oe = bus_addr_oe;
    prev_addr = bus_addr;
  end
  initial begin
    {rst_n, req_valid, req_write, req_size, req_addr, req_cs, req_wdata} = '0;
    {error_cnt, n_compared, prev_oe, prev_addr} = '0;
    cfg(4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h2);
    void'($urandom(32'h2736a381));
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    a = $urandom & 32'hffff_fff0;
    d = $urandom;
    issue(1'b1, csbw_pkg::SIZE_BYTE, a, 1'b0, d);
    issue(1'b1, csbw_pkg::SIZE_LONG, a + 32'h4, 1'b0, d);
    drain("single write");
    cfg(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    issue(1'b0, csbw_pkg::SIZE_LONG, a + 32'h4, 1'b1, d);
    drain("acknowledged read");
    cfg(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5);
    issue(1'b0, csbw_pkg::SIZE_LONG, a + 32'h4, 1'b1, d);
    drain("slow read");
    cfg(4'h2, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
    issue(1'b1, csbw_pkg::SIZE_BYTE, a + 32'h8, 1'b0, d);
    drain("wait states");
    cfg(4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h2);
    for (int s = 0; s < 4; s++)
      issue(1'b1, csbw_pkg::SIZE_LINE, a | 32'(s * 4), 1'b0, d);
    drain("burst writes");
    cfg(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2);
    issue(1'b0, csbw_pkg::SIZE_LINE, a | 32'hc, 1'b0, d);
    drain("burst read");
    for (int en = 0; en < 2; en++) begin
      cfg(4'h1, 1'b1, 1'(en), 1'(en), 1'b1, 4'h2);
      issue(1'b0, csbw_pkg::SIZE_LINE, a | 32'h4, 1'b0, d);
      issue(1'b1, csbw_pkg::SIZE_LONG, a + 32'h20, 1'b0, d);
      drain("word port line");
    end
    summarize();
  end
endmodule
`default_nettype wire
